// [hdl/timed_serdes_io_port.sv]
// one timed serialising i/o port with its clock block selection and pin sharing
// assumes pins, strobes and external clocks are synchronous to clk_i
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
module timed_serdes_io_port #(
    parameter int PORT_W = serdes_io_pkg::PORT_W_DEF,
    parameter int XFER_W = serdes_io_pkg::XFER_W_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [serdes_io_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic we_i,
    input wire logic re_i,
    output logic [31:0] rdata_o,
    input wire logic [PORT_W-1:0] pin_i,
    output logic [PORT_W-1:0] pin_o,
    output logic [PORT_W-1:0] pin_oe_n_o,
    output logic pulldown_en_o,
    input wire logic inbound_strobe_i,
    output logic outbound_strobe_o,
    input wire logic [serdes_io_pkg::NUM_CLK_BLOCKS-2:0] ext_clk_i,
    input wire logic link_enable_i,
    input wire logic [PORT_W-1:0] narrow_claim_i,
    output logic event_o
);
    localparam int RATIO = XFER_W / PORT_W;
    localparam int SW = $clog2(RATIO) + 1;
    localparam logic [SW-1:0] SLOTS = SW'(RATIO);
    localparam int CNT_W = serdes_io_pkg::CNT_W;

    // widths the serdes cannot serve are refused
    initial begin
        if (!(PORT_W inside {1, 4, 8, 16, 32}) || XFER_W > 32 || XFER_W % PORT_W != 0) begin
            $error("unsupported port or transfer width");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    serdes_io_pkg::ctrl_t ctrl_q, ctrl_d;
    logic [CNT_W-1:0] count_q, count_d, time_q, time_d, tstamp_q, tstamp_d;
    logic [PORT_W-1:0] cond_q, cond_d, pin_val_q, pin_val_d;
    logic [PORT_W-1:0] pin_q, pin_d, oe_n_q, oe_n_d;
    logic [XFER_W-1:0] tr_q, tr_d, oshift_q, oshift_d, ishift_q, ishift_d, rx_q, rx_d;
    logic [SW-1:0] oleft_q, oleft_d, icnt_q, icnt_d;
    logic tx_full_q, tx_full_d, rx_valid_q, rx_valid_d, wait_q, wait_d;
    logic strobe_q, strobe_d, event_q, event_d, pd_q, pd_d;
    logic [serdes_io_pkg::NUM_CLK_BLOCKS-2:0] ext_prev_q, ext_prev_d;
    logic [serdes_io_pkg::DIV_W-1:0] div_cnt_q, div_cnt_d;
    logic [31:0] rdata_q, rdata_d;

    logic owned, src_edge, tick, at_time, cond_ok, load_fire, rx_set, sample;
    logic [PORT_W-1:0] avail, pins_in;
    logic [serdes_io_pkg::NUM_CLK_BLOCKS-2:0] ext_rise;
    logic [2:0] ext_idx;

    ////////////////////////////////////////////////////////////////////////////
    // clock block selection and port tick
    always_comb begin
        ext_rise = ext_clk_i & ~ext_prev_q;
        ext_prev_d = ext_clk_i;
        ext_idx = 3'(ctrl_q.clk_sel - 3'h1);
        // block zero is the reference clock: one tick per clk_i edge
        if (ctrl_q.clk_sel == 3'h0) begin
            src_edge = 1'b1;
        end else if (ctrl_q.clk_sel < 3'(serdes_io_pkg::NUM_CLK_BLOCKS)) begin
            src_edge = ext_rise[ext_idx];
        end else begin
            src_edge = 1'b0;
        end
        // divide by div+1 for external sources; div of zero passes edges through
        tick = src_edge && (ctrl_q.clk_sel == 3'h0 || div_cnt_q == ctrl_q.div);
        div_cnt_d = div_cnt_q;
        if (src_edge && ctrl_q.clk_sel != 3'h0) begin
            div_cnt_d = (div_cnt_q == ctrl_q.div) ? '0 : div_cnt_q + 1'b1;
        end
        count_d = tick ? count_q + 1'b1 : count_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin ownership
    always_comb begin
        owned = ctrl_q.enable && !link_enable_i;
        // a narrower port's claim removes only its own pins from this port
        avail = owned ? ~narrow_claim_i : '0;
        pins_in = pin_i & avail;
        at_time = !ctrl_q.timed || count_q == time_q;
        case (ctrl_q.cond_mode)
            serdes_io_pkg::COND_EQ: cond_ok = pins_in == cond_q;
            serdes_io_pkg::COND_NE: cond_ok = pins_in != cond_q;
            default: cond_ok = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // serdes, transfer registers and register port
    always_comb begin
        ctrl_d = ctrl_q;
        time_d = time_q;
        cond_d = cond_q;
        tr_d = tr_q;
        tx_full_d = tx_full_q;
        oshift_d = oshift_q;
        oleft_d = oleft_q;
        pin_val_d = pin_val_q;
        ishift_d = ishift_q;
        icnt_d = icnt_q;
        rx_d = rx_q;
        rx_valid_d = rx_valid_q;
        wait_d = wait_q;
        tstamp_d = tstamp_q;
        strobe_d = 1'b0;
        event_d = 1'b0;
        load_fire = 1'b0;
        rx_set = 1'b0;
        sample = 1'b0;
        rdata_d = '0;

        // outbound: one port-width slice per tick, lsb slice first
        if (tick && owned && ctrl_q.dir_out) begin
            if (oleft_q != '0) begin
                pin_val_d = oshift_q[PORT_W-1:0];
                oshift_d = oshift_q >> PORT_W;
                oleft_d = oleft_q - 1'b1;
                strobe_d = 1'b1;
            end else if (tx_full_q && at_time) begin
                load_fire = 1'b1;
                pin_val_d = tr_q[PORT_W-1:0];
                oshift_d = tr_q >> PORT_W;
                oleft_d = SLOTS - 1'b1;
                tx_full_d = 1'b0;
                tstamp_d = count_q;
                strobe_d = 1'b1;
            end
        end

        // inbound: optional wait for a pin condition, optional strobe qualify
        if (tick && owned && !ctrl_q.dir_out) begin
            if (wait_q && cond_ok) begin
                wait_d = 1'b0;
            end
            sample = (!wait_q || cond_ok) && (!ctrl_q.strobe_en || inbound_strobe_i)
                && (icnt_q != '0 || at_time);
            if (sample) begin
                ishift_d = (ishift_q >> PORT_W) | (XFER_W'(pins_in) << (XFER_W - PORT_W));
                if (icnt_q == SLOTS - 1'b1) begin
                    icnt_d = '0;
                    rx_set = 1'b1;
                    rx_d = (ishift_q >> PORT_W) | (XFER_W'(pins_in) << (XFER_W - PORT_W));
                    tstamp_d = count_q;
                    event_d = 1'b1;
                end else begin
                    icnt_d = icnt_q + 1'b1;
                end
            end
        end

        // register writes; a write to a full transfer register is dropped
        if (we_i) begin
            case (addr_i)
                serdes_io_pkg::REG_CTRL: begin
                    ctrl_d = serdes_io_pkg::ctrl_t'(wdata_i[serdes_io_pkg::CTRL_W-1:0]);
                    // a condition mode other than none arms the wait
                    wait_d = ctrl_d.cond_mode != serdes_io_pkg::COND_NONE;
                    oleft_d = '0;
                    icnt_d = '0;
                end
                serdes_io_pkg::REG_DATA: begin
                    if (!tx_full_q) begin
                        tr_d = wdata_i[XFER_W-1:0];
                        tx_full_d = 1'b1;
                    end
                end
                serdes_io_pkg::REG_TIME: time_d = wdata_i[CNT_W-1:0];
                serdes_io_pkg::REG_COND: cond_d = wdata_i[PORT_W-1:0];
                default: ;
            endcase
        end

        // register reads; reading data clears valid, a new word in the same cycle wins
        if (re_i) begin
            case (addr_i)
                serdes_io_pkg::REG_CTRL: rdata_d = 32'(ctrl_q);
                serdes_io_pkg::REG_DATA: begin
                    rdata_d = 32'(rx_q);
                    rx_valid_d = 1'b0;
                end
                serdes_io_pkg::REG_COUNT: rdata_d = 32'(count_q);
                serdes_io_pkg::REG_TSTAMP: rdata_d = 32'(tstamp_q);
                serdes_io_pkg::REG_TIME: rdata_d = 32'(time_q);
                serdes_io_pkg::REG_COND: rdata_d = 32'(cond_q);
                serdes_io_pkg::REG_STATUS: begin
                    rdata_d[serdes_io_pkg::ST_TX_FULL] = tx_full_q;
                    rdata_d[serdes_io_pkg::ST_RX_VALID] = rx_valid_q;
                    rdata_d[serdes_io_pkg::ST_WAIT] = wait_q;
                    rdata_d[serdes_io_pkg::ST_OWNED] = owned;
                end
                default: rdata_d = '0;
            endcase
        end
        if (rx_set) begin
            rx_valid_d = 1'b1;
        end
        pd_d = !ctrl_d.enable;
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers; one direction for the whole port
    for (genvar b = 0; b < PORT_W; b++) begin : g_pin
        always_comb begin
            if (ctrl_d.oc) begin
                pin_d[b] = 1'b0;
                oe_n_d[b] = !(avail[b] && ctrl_d.dir_out && !pin_val_d[b]);
            end else begin
                pin_d[b] = pin_val_d[b];
                oe_n_d[b] = !(avail[b] && ctrl_d.dir_out);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= serdes_io_pkg::CTRL_RST;
            count_q <= serdes_io_pkg::CNT_RST;
            time_q <= serdes_io_pkg::CNT_RST;
            tstamp_q <= serdes_io_pkg::CNT_RST;
            cond_q <= '0;
            pin_val_q <= '0;
            pin_q <= '0;
            oe_n_q <= '1;
            tr_q <= '0;
            oshift_q <= '0;
            ishift_q <= '0;
            rx_q <= '0;
            oleft_q <= '0;
            icnt_q <= '0;
            tx_full_q <= 1'b0;
            rx_valid_q <= 1'b0;
            wait_q <= 1'b0;
            strobe_q <= 1'b0;
            event_q <= 1'b0;
            pd_q <= 1'b1;
            ext_prev_q <= '0;
            div_cnt_q <= '0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            time_q <= time_d;
            tstamp_q <= tstamp_d;
            cond_q <= cond_d;
            pin_val_q <= pin_val_d;
            pin_q <= pin_d;
            oe_n_q <= oe_n_d;
            tr_q <= tr_d;
            oshift_q <= oshift_d;
            ishift_q <= ishift_d;
            rx_q <= rx_d;
            oleft_q <= oleft_d;
            icnt_q <= icnt_d;
            tx_full_q <= tx_full_d;
            rx_valid_q <= rx_valid_d;
            wait_q <= wait_d;
            strobe_q <= strobe_d;
            event_q <= event_d;
            pd_q <= pd_d;
            ext_prev_q <= ext_prev_d;
            div_cnt_q <= div_cnt_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign pin_o = pin_q;
    assign pin_oe_n_o = oe_n_q;
    assign pulldown_en_o = pd_q;
    assign outbound_strobe_o = strobe_q;
    assign event_o = event_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_COUNT_READ: assert property (re_i && addr_i == serdes_io_pkg::REG_COUNT
        |=> rdata_o == 32'($past(count_q)))
        else $error("count read mismatch");
    AST_OC_NEVER_HIGH: assert property ($past(ctrl_d.oc) |-> pin_o == '0)
        else $error("open collector pin driven high");
    AST_LINK_RELEASE: assert property (link_enable_i |=> pin_oe_n_o == '1)
        else $error("pin driven while link owns it");
    AST_CLAIM_RELEASE: assert property (narrow_claim_i[0] |=> pin_oe_n_o[0])
        else $error("claimed pin still driven");
    AST_COUNT_WRAP: assert property (tick && count_q == 16'hffff |=> count_q == 16'h0000)
        else $error("counter did not wrap");
    AST_STROBE_DATA: assert property (load_fire
        |=> outbound_strobe_o && pin_val_q == $past(tr_q[PORT_W-1:0]) && !tx_full_q)
        else $error("strobe not with data");
    AST_EVENT_STAMP: assert property (rx_set |=> event_o && rx_valid_q
        && tstamp_q == $past(count_q) ##1 !event_o)
        else $error("event or timestamp wrong");
    AST_RESET_CLOCK: assert property ($past(rst_i) |-> ctrl_q.clk_sel == 3'h0 && pulldown_en_o)
        else $error("reset state wrong");
    AST_INPUT_UNDRIVEN: assert property (!ctrl_d.dir_out |=> pin_oe_n_o == '1)
        else $error("input port drives pins");
    AST_TIMED_LOAD: assert property (load_fire && ctrl_q.timed |-> count_q == time_q)
        else $error("timed transfer off its count");


    // pins and pull-down
    AST_OC_ONE_FLOATS: assert property (ctrl_d.oc && pin_val_d == '1 |=> pin_oe_n_o == '1)
        else $error("open collector one not released");
    AST_PULLDOWN_IDLE: assert property (!ctrl_d.enable |=> pulldown_en_o)
        else $error("pull-down off while port disabled");
    AST_UNOWNED_QUIET: assert property (!owned |=> !outbound_strobe_o && !event_o)
        else $error("activity on pins not owned");

    // sampling qualifiers
    AST_SAMPLE_STROBE: assert property (sample |-> !ctrl_q.strobe_en || inbound_strobe_i)
        else $error("sample taken without inbound strobe");
    AST_WAIT_NO_SAMPLE: assert property (wait_q && !cond_ok |-> !sample)
        else $error("sample taken before condition met");

    // counter, timestamp and read port
    AST_NO_TICK_HOLD: assert property (!tick |=> $stable(count_q))
        else $error("counter moved without a tick");
    AST_NO_SOURCE: assert property (ctrl_q.clk_sel > 3'h5 |-> !tick)
        else $error("tick from an absent clock block");
    AST_TSTAMP_HOLD: assert property (!load_fire && !rx_set |=> $stable(tstamp_q))
        else $error("timestamp changed without a transfer");
    AST_READ_ONE_CYCLE: assert property (!re_i |=> rdata_o == '0)
        else $error("read data outside its cycle");

    // main scenarios
    COV_TX_LOAD: cover property (load_fire ##1 outbound_strobe_o);
    COV_OC_WORD: cover property (load_fire && ctrl_q.oc);
    COV_TIMED_LOAD: cover property (load_fire && ctrl_q.timed);
    COV_RX_WORD: cover property (rx_set ##1 event_o);
    COV_COND_MET: cover property (wait_q ##1 !wait_q);
endmodule

// [shared/serdes_io_pkg.sv]
// constants, field layouts and carrier types for the timed serdes i/o port
// assumes a single clock domain and a plain single-cycle register port
package serdes_io_pkg;
    localparam int PORT_W_DEF = 4;
    localparam int XFER_W_DEF = 32;
    localparam int CNT_W = 16;
    localparam int NUM_CLK_BLOCKS = 6;
    localparam int REF_CLK_MHZ = 100;
    localparam int ADDR_W = 3;
    localparam int DIV_W = 8;

    localparam logic [ADDR_W-1:0] REG_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] REG_DATA = 3'h1;
    localparam logic [ADDR_W-1:0] REG_COUNT = 3'h2;
    localparam logic [ADDR_W-1:0] REG_TSTAMP = 3'h3;
    localparam logic [ADDR_W-1:0] REG_TIME = 3'h4;
    localparam logic [ADDR_W-1:0] REG_COND = 3'h5;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h6;

    localparam int ST_TX_FULL = 0;
    localparam int ST_RX_VALID = 1;
    localparam int ST_WAIT = 2;
    localparam int ST_OWNED = 3;

    typedef enum logic [1:0] {
        COND_NONE,
        COND_EQ,
        COND_NE,
        COND_RSV
    } cond_mode_t;

    // msb first: div, timed, cond_mode, clk_sel, strobe_en, oc, dir_out, enable
    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic timed;
        cond_mode_t cond_mode;
        logic [2:0] clk_sel;
        logic strobe_en;
        logic oc;
        logic dir_out;
        logic enable;
    } ctrl_t;

    localparam int CTRL_W = $bits(ctrl_t);
    localparam ctrl_t CTRL_RST = '0;
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
endpackage

// [sim/ext_pin_model.sv]
// external hardware on the port pins: drives input data with a ready strobe,
// captures output slices on the outbound strobe
// assumes the pins are synchronous to clk_i and an external pull-up on each pin
`timescale 1ns/1ps
module ext_pin_model #(
    parameter int W = 4
) (
    input wire logic clk_i,
    input wire logic clear_i,
    input wire logic [W-1:0] pin_o_i,
    input wire logic [W-1:0] pin_oe_n_i,
    input wire logic pulldown_en_i,
    input wire logic outbound_strobe_i,
    input wire logic drive_en_i,
    input wire logic [W-1:0] drive_val_i,
    output logic [W-1:0] pin_level_o,
    output logic inbound_strobe_o,
    output logic [31:0] got_word_o,
    output logic [31:0] got_oe_o,
    output logic [7:0] got_cnt_o
);
    logic phase_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // strobe every other cycle; off-strobe data is inverted so unqualified
    // sampling shows up as a corrupted word
    always_ff @(posedge clk_i) begin
        phase_q <= ~phase_q;
    end
    assign inbound_strobe_o = phase_q;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (drive_en_i) begin
                pin_level_o[i] = phase_q ? drive_val_i[i] : ~drive_val_i[i];
            end else if (!pin_oe_n_i[i]) begin
                pin_level_o[i] = pin_o_i[i];
            end else begin
                pin_level_o[i] = ~pulldown_en_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // lsb slice arrives first, so shift in from the top
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            got_word_o <= 32'h0;
            got_oe_o <= 32'h0;
            got_cnt_o <= 8'h0;
        end else if (outbound_strobe_i) begin
            got_word_o <= {pin_level_o, got_word_o[31:W]};
            got_oe_o <= {~pin_oe_n_i, got_oe_o[31:W]};
            got_cnt_o <= got_cnt_o + 8'h1;
        end
    end
endmodule

// [sim/test_timed_serdes_io_port.sv]
// self-checking bench for the timed serdes i/o port, 4-pin instance
// assumes the register map and control layout of the serdes_io_pkg package
`timescale 1ns/1ps
module test_timed_serdes_io_port;
    localparam int PW = 4;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [serdes_io_pkg::ADDR_W-1:0] addr_i = '0;
    logic [31:0] wdata_i = 32'h0;
    logic we_i = 1'b0;
    logic re_i = 1'b0;
    logic [31:0] rdata_o;
    logic [PW-1:0] pin_lvl, pin_o, pin_oe_n_o;
    logic [PW-1:0] narrow_claim_i = '0;
    logic [PW-1:0] drive_val = '0;
    logic pulldown_en_o, inbound_strobe_i, outbound_strobe_o, event_o;
    logic link_enable_i = 1'b0;
    logic drive_en = 1'b0;
    logic clear = 1'b1;
    logic [2:0] ext_div = 3'h0;
    logic [31:0] got_word, got_oe, v, c, t;
    logic [7:0] got_cnt;
    logic seen;
    int n_mismatch = 0;
    int n_tests = 0;

    always #20 clk_i = ~clk_i;
    // slow external clock: one rising edge every 8 cycles
    always @(posedge clk_i) ext_div <= ext_div + 3'h1;

    timed_serdes_io_port #(.PORT_W(PW), .XFER_W(32)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
        .re_i(re_i), .rdata_o(rdata_o), .pin_i(pin_lvl), .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o), .pulldown_en_o(pulldown_en_o),
        .inbound_strobe_i(inbound_strobe_i), .outbound_strobe_o(outbound_strobe_o),
        .ext_clk_i({4'h0, ext_div[2]}), .link_enable_i(link_enable_i),
        .narrow_claim_i(narrow_claim_i), .event_o(event_o));

    ext_pin_model #(.W(PW)) far (
        .clk_i(clk_i), .clear_i(clear), .pin_o_i(pin_o), .pin_oe_n_i(pin_oe_n_o),
        .pulldown_en_i(pulldown_en_o), .outbound_strobe_i(outbound_strobe_o),
        .drive_en_i(drive_en), .drive_val_i(drive_val), .pin_level_o(pin_lvl),
        .inbound_strobe_o(inbound_strobe_i), .got_word_o(got_word), .got_oe_o(got_oe),
        .got_cnt_o(got_cnt));

    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t word got %h want %h", $time, g, e);
        end
    endtask

    task automatic cmp_pins(input logic [PW-1:0] g, input logic [PW-1:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t pins got %h want %h", $time, g, e);
        end
    endtask

    // bounded waits so a stuck port fails instead of hanging
    task automatic wait_slices(input logic [7:0] n);
        for (int i = 0; i < 300 && got_cnt != n; i++) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_ev(output logic s);
        s = 1'b0;
        for (int i = 0; i < 300 && !s; i++) begin
            @(posedge clk_i);
            #1;
            s = (event_o === 1'b1);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(40 * 20000);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (15) @(posedge clk_i);
        #1;
        cmp32({31'h0, pulldown_en_o}, 32'h1);
        cmp_pins(pin_oe_n_o, 4'hf);
        @(posedge clk_i);
        rst_i <= 1'b0;
        clear <= 1'b0;
        rd(serdes_io_pkg::REG_CTRL, v);
        cmp32(v, 32'h0);
        wr(serdes_io_pkg::REG_CTRL, 32'h1);
        rd(serdes_io_pkg::REG_COUNT, c);
        rd(serdes_io_pkg::REG_COUNT, v);
        cmp32({16'h0, v[15:0] - c[15:0]}, 32'h2);
        // external clock block, undivided then divided by two
        for (int k = 0; k < 2; k++) begin
            wr(serdes_io_pkg::REG_CTRL, (k == 1) ? 32'h411 : 32'h11);
            rd(serdes_io_pkg::REG_COUNT, c);
            repeat (78) @(posedge clk_i);
            rd(serdes_io_pkg::REG_COUNT, v);
            cmp32({16'h0, v[15:0] - c[15:0]}, (k == 1) ? 32'h5 : 32'ha);
        end
        wr(serdes_io_pkg::REG_TIME, 32'h1234);
        rd(serdes_io_pkg::REG_TIME, v);
        cmp32(v, 32'h1234);
        rd(3'h7, v);
        cmp32(v, 32'h0);
        // push-pull then open collector output words
        for (int k = 0; k < 2; k++) begin
            t = (k == 1) ? 32'h0f0f00ff : 32'h87654321;
            wr(serdes_io_pkg::REG_CTRL, (k == 1) ? 32'h0f : 32'h0b);
            @(posedge clk_i);
            clear <= 1'b1;
            @(posedge clk_i);
            clear <= 1'b0;
            wr(serdes_io_pkg::REG_DATA, t);
            wait_slices(8'h8);
            cmp32(got_word, t);
            cmp32(got_oe, (k == 1) ? ~t : 32'hffffffff);
        end
        narrow_claim_i <= 4'h3;
        repeat (2) @(posedge clk_i);
        #1;
        cmp_pins(pin_oe_n_o, 4'h3);
        narrow_claim_i <= 4'h0;
        link_enable_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        cmp_pins(pin_oe_n_o, 4'hf);
        rd(serdes_io_pkg::REG_STATUS, v);
        cmp32(v & 32'h8, 32'h0);
        link_enable_i <= 1'b0;
        // timed output word held back until the count matches
        clear <= 1'b1;
        wr(serdes_io_pkg::REG_CTRL, 32'h20b);
        clear <= 1'b0;
        rd(serdes_io_pkg::REG_COUNT, c);
        t = {16'h0, c[15:0] + 16'd60};
        wr(serdes_io_pkg::REG_TIME, t);
        wr(serdes_io_pkg::REG_DATA, 32'hcafe1234);
        repeat (20) @(posedge clk_i);
        rd(serdes_io_pkg::REG_STATUS, v);
        cmp32(v & 32'h1, 32'h1);
        cmp32({24'h0, got_cnt}, 32'h0);
        wait_slices(8'h8);
        cmp32(got_word, 32'hcafe1234);
        rd(serdes_io_pkg::REG_TSTAMP, v);
        cmp32({31'h0, (v[15:0] - t[15:0]) < 16'd4}, 32'h1);
        // strobed input
        drive_en <= 1'b1;
        drive_val <= 4'h5;
        wr(serdes_io_pkg::REG_CTRL, 32'h09);
        @(posedge clk_i);
        #1;
        cmp_pins(pin_oe_n_o, 4'hf);
        wait_ev(seen);
        cmp32({31'h0, seen}, 32'h1);
        @(posedge clk_i);
        #1;
        cmp32({31'h0, event_o}, 32'h0);
        rd(serdes_io_pkg::REG_COUNT, c);
        rd(serdes_io_pkg::REG_TSTAMP, v);
        cmp32({31'h0, (c[15:0] - v[15:0]) < 16'd8}, 32'h1);
        rd(serdes_io_pkg::REG_DATA, v);
        cmp32(v, 32'h55555555);
        rd(serdes_io_pkg::REG_STATUS, v);
        cmp32(v & 32'h2, 32'h0);
        // conditional input: nothing lands until the pins equal the compare value
        drive_val <= 4'h3;
        wr(serdes_io_pkg::REG_COND, 32'h5);
        wr(serdes_io_pkg::REG_CTRL, 32'h89);
        rd(serdes_io_pkg::REG_DATA, v);
        repeat (40) @(posedge clk_i);
        rd(serdes_io_pkg::REG_STATUS, v);
        cmp32(v & 32'h6, 32'h4);
        drive_val <= 4'h5;
        wait_ev(seen);
        cmp32({31'h0, seen}, 32'h1);
        rd(serdes_io_pkg::REG_DATA, v);
        cmp32(v, 32'h55555555);
        complete_run();
    end
endmodule
